// >>> hw/gci_mon_pkg.sv
// shared constants and types of the monitor-channel register access block
// assumes a 200 MHz reference clock and a frame of two 32-bit channels
package gci_mon_pkg;

  // timing: clock-loss detection window, derived in cycles of ref_clk
  localparam int CLK_PERIOD_NS   = 5;
  localparam int IDLE_TIMEOUT_NS = 4000;
  localparam int IDLE_CYCLES     = (IDLE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_CNT_W      = 10;
  localparam logic [IDLE_CNT_W-1:0] IDLE_LIMIT = IDLE_CNT_W'(IDLE_CYCLES);

  // frame position: half-bit counter of bit-clock rising edges
  localparam int              HALF_W        = 7;
  localparam logic [HALF_W-1:0] HALF_MAX    = 7'h7F;
  localparam logic [5:0]      MON_FIRST_BIT = 6'h30;  // first bit of monitor byte
  localparam logic [5:0]      MON_LAST_BIT  = 6'h37;  // last bit of monitor byte
  localparam logic [5:0]      ACK_BIT       = 6'h3E;  // acknowledge bit slot
  localparam logic [5:0]      EMIT_BIT      = 6'h3F;  // byte-present bit slot

  // instruction and chip select fields
  localparam int INSTR_POWER  = 7;
  localparam int INSTR_READ   = 2;
  localparam int INSTR_SECOND = 1;
  localparam int CODE_HI      = 6;
  localparam int CODE_LO      = 3;
  localparam int CS_ADDR_HI   = 7;
  localparam int CS_ADDR_LO   = 4;

  // register codes
  localparam logic [3:0] REG_FORMAT    = 4'h0;
  localparam logic [3:0] REG_TX_INJECT = 4'h3;
  localparam logic [3:0] REG_LAST_READ = 4'h9;
  localparam logic [3:0] REG_TEST      = 4'hA;
  localparam int         REG_DEPTH     = 16;
  localparam int         FIFO_DEPTH    = 32;
  localparam logic [7:0] FORMAT_RESET  = 8'h00;
  localparam logic [1:0] RUN_TWO       = 2'h2;

  // format_config layout, bit 7 first
  typedef struct packed {
    logic clockRateSelHi;
    logic clockRateSelLo;
    logic compandingLawSel;
    logic evenBitInvertSel;
    logic dataTimingSel;
    logic slotSpacingSel;
    logic slotLengthSel;
    logic digitalLoopback;
  } format_cfg_t;

  // one committed register write
  typedef struct packed {
    logic [3:0] code;
    logic [7:0] data;
  } reg_write_t;

  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_FIRST  = 3'b001,
    RX_ACKED  = 3'b010,
    RX_NEXT   = 3'b011,
    RX_PREACK = 3'b100,
    RX_ABORT  = 3'b101,
    RX_IGNORE = 3'b110
  } rx_mode_t;

  typedef enum logic [0:0] {
    PH_INSTR = 1'b0,
    PH_DATA  = 1'b1
  } cmd_phase_t;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_LOAD  = 3'b001,
    TX_LATCH = 3'b010,
    TX_ARM   = 3'b011,
    TX_SEND  = 3'b100,
    TX_CLOSE = 3'b101
  } tx_state_t;

endpackage : gci_mon_pkg

// >>> hw/mon_write_fifo.sv
// first-in first-out buffer for committed register writes
// assumes one clock; pointers wrap, so depth is a power of two
module mon_write_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,       // block clock
  input  wire logic             rst_n,     // async reset, low active
  input  wire logic             en,        // clock enable
  input  wire logic             inValid,   // write offered
  output logic                  inReady,   // room for a word
  input  wire logic [WIDTH-1:0] inData,    // word to store
  output logic                  outValid,  // word available
  input  wire logic             outReady,  // drain accepts word
  output logic      [WIDTH-1:0] outData    // oldest word
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [AW:0]                 count;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic        doPush;
  logic        doPop;

  ////////////////////////////////////////////////////////////////////////////
  // honest flags straight from the occupancy count
  assign inReady  = st.count != (AW+1)'(DEPTH);
  assign outValid = st.count != '0;
  assign outData  = st.slot[st.rdPtr];
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;

  // push and pop may share a cycle; count then stands still
  always_comb begin
    next_st = st;
    if (doPush) begin
      next_st.slot[st.wrPtr] = inData;
      next_st.wrPtr          = st.wrPtr + 1'b1;
    end
    if (doPop) begin
      next_st.rdPtr = st.rdPtr + 1'b1;
    end
    unique case ({doPush, doPop})
      2'b10:   next_st.count = st.count + 1'b1;
      2'b01:   next_st.count = st.count - 1'b1;
      default: next_st.count = st.count;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else if (en) begin
      st <= next_st;
    end
  end
endmodule : mon_write_fifo

// >>> hw/mon_reg_store.sv
// small register image, one write port and a registered read port
// assumes the caller waits one cycle for read data
module mon_reg_store #(
  parameter int DEPTH = 16
) (
  input  wire logic                     clk,     // block clock
  input  wire logic                     rst_n,   // async reset, low active
  input  wire logic                     en,      // clock enable
  input  wire logic                     wrEn,    // write strobe
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,  // write code
  input  wire logic [7:0]               wrData,  // write byte
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,  // read code
  output logic      [7:0]               rdData   // registered read byte
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] word;
    logic [7:0]            rdData;
  } store_state_t;

  store_state_t st;
  store_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // read reflects contents before a same-cycle write
  always_comb begin
    next_st        = st;
    next_st.rdData = st.word[rdAddr];
    if (wrEn) begin
      next_st.word[wrAddr] = wrData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else if (en) begin
      st <= next_st;
    end
  end

  assign rdData = st.rdData;
endmodule : mon_reg_store

// >>> hw/gci_monitor_register_access.sv
// monitor-channel register access: byte handshake, decode, format register
// assumes bit clock, frame sync and receive data arrive asynchronously to ref_clk
module gci_monitor_register_access (
  input  wire logic                     ref_clk,            // 200 MHz block clock
  input  wire logic                     rst_n,              // async reset, low active
  input  wire logic                     clkEn,              // freezes all state when low
  input  wire logic                     bitClk,             // link bit clock, asynchronous
  input  wire logic                     frameSync,          // frame sync, asynchronous
  input  wire logic                     receiveDataPin,     // serial data in
  input  wire logic [3:0]               deviceAddressPins,  // strapped device address
  output logic                          transmitDataPin,    // open-drain data out level
  output logic                          transmitDataOe,     // high while pulling low
  output gci_mon_pkg::format_cfg_t      formatConfig,       // format register
  output logic                          powerDown,          // power control state
  output logic                          wrValid,            // committed write available
  input  wire logic                     wrReady,            // consumer takes write
  output gci_mon_pkg::reg_write_t       wrEntry             // committed write
);
  import gci_mon_pkg::*;

  typedef struct packed {
    logic        bclkS1;
    logic        bclkS2;
    logic        bclkPrev;
    logic        fsS1;
    logic        fsS2;
    logic        fsPrev;
    logic        drS1;
    logic        drS2;
    logic [3:0]  adrS1;
    logic [3:0]  adrS2;
    logic        fsSeen;
    logic [HALF_W-1:0] halfCnt;
    logic [IDLE_CNT_W-1:0] idleCnt;
    logic [7:0]  shiftIn;
    logic        rxAckBit;
    rx_mode_t    rxMode;
    logic [7:0]  prevByte;
    logic [1:0]  eIdleRun;
    logic [1:0]  aIdleRun;
    logic        aDrive;
    cmd_phase_t  phase;
    logic [3:0]  wrCode;
    format_cfg_t format;
    logic        powerUp;
    logic        memWe;
    logic [7:0]  memWData;
    logic        push;
    reg_write_t  pushEntry;
    tx_state_t   txState;
    logic [3:0]  txCode;
    logic [7:0]  txByte;
    logic        eDrive;
    logic        oe;
  } state_t;

  localparam state_t ST_RESET = '0;

  state_t            st;
  state_t            next_st;
  logic              mclkRise;
  logic              fsRise;
  logic [HALF_W-1:0] halfNext;
  logic              sampleNow;
  logic              driveNow;
  logic [5:0]        bitIdx;
  logic              inMonSlot;
  logic              frameDone;
  logic              eActNow;
  logic              sameByte;
  logic              addrMatch;
  logic              clocksIdle;
  logic              fifoReady;
  logic [7:0]        memRdData;
  logic [3:0]        byteCode;
  logic              readable;

  ////////////////////////////////////////////////////////////////////////////
  // edge finding on synchronised link signals; first flops feed only the second
  assign mclkRise   = st.bclkS2 & ~st.bclkPrev;
  assign fsRise     = st.fsS2 & ~st.fsPrev;
  assign halfNext   = (st.fsSeen | fsRise) ? '0 :
                      (st.halfCnt == HALF_MAX) ? HALF_MAX : st.halfCnt + 1'b1;
  assign bitIdx     = halfNext[HALF_W-1:1];
  assign sampleNow  = mclkRise & halfNext[0];   // one bit clock after launch
  assign driveNow   = mclkRise & ~halfNext[0];
  assign inMonSlot  = (bitIdx >= MON_FIRST_BIT) && (bitIdx <= MON_LAST_BIT);
  assign frameDone  = sampleNow && (bitIdx == EMIT_BIT);
  assign eActNow    = ~st.drS2;                 // low active byte-present bit
  assign sameByte   = st.shiftIn == st.prevByte;
  assign addrMatch  = st.shiftIn[CS_ADDR_HI:CS_ADDR_LO] == st.adrS2;
  assign clocksIdle = st.idleCnt == IDLE_LIMIT;
  assign byteCode   = st.shiftIn[CODE_HI:CODE_LO];
  // transmit-inject and test codes give no read-back
  assign readable   = (byteCode <= REG_LAST_READ) && (byteCode != REG_TX_INJECT);

  ////////////////////////////////////////////////////////////////////////////
  // next state of the whole block
  always_comb begin
    next_st          = st;
    next_st.bclkS1   = bitClk;
    next_st.bclkS2   = st.bclkS1;
    next_st.bclkPrev = st.bclkS2;
    next_st.fsS1     = frameSync;
    next_st.fsS2     = st.fsS1;
    next_st.fsPrev   = st.fsS2;
    next_st.drS1     = receiveDataPin;
    next_st.drS2     = st.drS1;
    next_st.adrS1    = deviceAddressPins;
    next_st.adrS2    = st.adrS1;
    next_st.memWe    = 1'b0;
    next_st.push     = 1'b0;

    // frame position restarts on the first bit clock after sync rises
    if (mclkRise) begin
      next_st.fsSeen  = 1'b0;
      next_st.halfCnt = halfNext;
      next_st.idleCnt = '0;
    end else begin
      if (fsRise) begin
        next_st.fsSeen = 1'b1;
      end
      if (!clocksIdle) begin
        next_st.idleCnt = st.idleCnt + 1'b1;
      end
    end

    // sample at fixed frame positions
    if (sampleNow) begin
      if (inMonSlot) begin
        next_st.shiftIn = {st.shiftIn[6:0], st.drS2};
      end
      if (bitIdx == ACK_BIT) begin
        next_st.rxAckBit = ~st.drS2;
      end
    end

    // drive only zeros; a one or an idle bit is left to the pull-up
    if (driveNow) begin
      if (inMonSlot) begin
        next_st.oe = st.eDrive & ~st.txByte[3'(MON_LAST_BIT - bitIdx)];
      end else if (bitIdx == ACK_BIT) begin
        next_st.oe = st.aDrive;
      end else if (bitIdx == EMIT_BIT) begin
        next_st.oe = st.eDrive;
      end else begin
        next_st.oe = 1'b0;
      end
    end

    // read reply fetch: one cycle for the store, one to latch
    unique case (st.txState)
      TX_LOAD:  next_st.txState = TX_LATCH;
      TX_LATCH: begin
        next_st.txByte  = (st.txCode == REG_FORMAT) ? 8'(st.format) : memRdData;
        next_st.txState = TX_ARM;
      end
      default: ;
    endcase

    if (frameDone) begin
      next_st.eIdleRun = eActNow ? '0 : (st.eIdleRun == RUN_TWO) ? RUN_TWO : st.eIdleRun + 1'b1;
      next_st.aIdleRun = st.rxAckBit ? '0 : (st.aIdleRun == RUN_TWO) ? RUN_TWO : st.aIdleRun + 1'b1;

      // reply sender, one byte per message
      unique case (st.txState)
        TX_ARM: begin
          if (next_st.aIdleRun == RUN_TWO) begin
            next_st.eDrive  = 1'b1;
            next_st.txState = TX_SEND;
          end
        end
        TX_SEND: begin
          if (st.rxAckBit) begin
            next_st.eDrive  = 1'b0;
            next_st.txState = TX_CLOSE;
          end
        end
        // only an ack or stopped clocks end the reply; no abort path, no retry
        TX_CLOSE: next_st.txState = TX_IDLE;
        default: ;
      endcase

      // receiver of controller messages
      unique case (st.rxMode)
        RX_IDLE: begin
          next_st.aDrive = 1'b0;
          if (eActNow) begin
            next_st.prevByte = st.shiftIn;
            next_st.rxMode   = RX_FIRST;
          end
        end
        RX_FIRST: begin
          if (!eActNow) begin
            next_st.rxMode = RX_IDLE;
          end else if (sameByte && addrMatch) begin
            next_st.aDrive = 1'b1;
            next_st.phase  = PH_INSTR;
            next_st.rxMode = RX_ACKED;
          end else begin
            next_st.rxMode = RX_IGNORE;
          end
        end
        RX_ACKED: begin
          if (!eActNow) begin
            next_st.prevByte = st.shiftIn;
            next_st.rxMode   = RX_NEXT;
          end
        end
        RX_NEXT: begin
          if (!eActNow) begin
            next_st.aDrive = 1'b0;
            next_st.rxMode = RX_IDLE;
          end else if (!sameByte || (st.phase == PH_DATA && !fifoReady)) begin
            next_st.aDrive = 1'b0;
            next_st.rxMode = RX_ABORT;
          end else begin
            next_st.aDrive = 1'b0;
            next_st.rxMode = RX_PREACK;
            if (st.phase == PH_INSTR) begin
              next_st.powerUp = ~st.shiftIn[INSTR_POWER];
              if (st.shiftIn[INSTR_SECOND] && st.shiftIn[INSTR_READ]) begin
                if (readable && st.txState == TX_IDLE) begin
                  next_st.txCode  = byteCode;
                  next_st.txState = TX_LOAD;
                end
              end else if (st.shiftIn[INSTR_SECOND]) begin
                next_st.wrCode = byteCode;
                next_st.phase  = PH_DATA;
              end
            end else begin
              if (st.wrCode == REG_FORMAT) begin
                next_st.format = format_cfg_t'(st.shiftIn);
              end
              if (st.wrCode <= REG_TEST) begin
                next_st.memWe     = 1'b1;
                next_st.memWData  = st.shiftIn;
                next_st.push      = 1'b1;
                next_st.pushEntry = '{code: st.wrCode, data: st.shiftIn};
              end
              next_st.phase = PH_INSTR;
            end
          end
        end
        RX_PREACK: begin
          next_st.aDrive = 1'b1;
          next_st.rxMode = RX_ACKED;
        end
        RX_ABORT: begin
          next_st.aDrive = 1'b0;
          next_st.rxMode = RX_IGNORE;
        end
        RX_IGNORE: begin
          next_st.aDrive = 1'b0;
          if (next_st.eIdleRun == RUN_TWO) begin
            next_st.rxMode = RX_IDLE;
          end
        end
        default: next_st.rxMode = RX_IDLE;
      endcase
    end

    // stopped clocks: drop every handshake, release the line, power down
    if (clocksIdle) begin
      next_st.rxMode   = RX_IDLE;
      next_st.phase    = PH_INSTR;
      next_st.aDrive   = 1'b0;
      next_st.eDrive   = 1'b0;
      next_st.oe       = 1'b0;
      next_st.txState  = TX_IDLE;
      next_st.eIdleRun = '0;
      next_st.aIdleRun = '0;
      next_st.powerUp  = 1'b0;
    end
  end

  // format register comes up zero with the rest of the state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RESET;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register image and write queue
  mon_reg_store #(
    .DEPTH (REG_DEPTH)
  ) u_store (
    .clk    (ref_clk),
    .rst_n  (rst_n),
    .en     (clkEn),
    .wrEn   (st.memWe),
    .wrAddr (st.pushEntry.code),
    .wrData (st.memWData),
    .rdAddr (st.txCode),
    .rdData (memRdData)
  );

  // a full queue turns the data byte into an abort rather than stalling
  mon_write_fifo #(
    .WIDTH ($bits(reg_write_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .en       (clkEn),
    .inValid  (st.push),
    .inReady  (fifoReady),
    .inData   (st.pushEntry),
    .outValid (wrValid),
    .outReady (wrReady),
    .outData  (wrEntry)
  );

  assign transmitDataPin = 1'b0;                  // open drain: only ever pulls low
  assign transmitDataOe  = st.oe;
  assign formatConfig    = st.format;
  assign powerDown       = ~st.powerUp;

  ////////////////////////////////////////////////////////////////////////////
  // checks on the handshake
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  cs_mismatch_a: assert property (
    clkEn && frameDone && eActNow && st.rxMode == RX_FIRST && sameByte && !addrMatch
    |=> st.rxMode == RX_IGNORE && !st.aDrive) else $error("foreign chip select acknowledged");

  byte_repeat_a: assert property (
    clkEn && frameDone && eActNow && st.rxMode == RX_FIRST && !sameByte
    |=> st.rxMode == RX_IGNORE) else $error("unrepeated byte accepted");

  first_ack_a: assert property (
    clkEn && frameDone && eActNow && st.rxMode == RX_FIRST && sameByte && addrMatch
    |=> st.aDrive && st.rxMode == RX_ACKED) else $error("first byte not acknowledged");

  preack_seq_a: assert property (
    clkEn && frameDone && eActNow && st.rxMode == RX_NEXT && sameByte && st.phase == PH_INSTR
    |=> !st.aDrive && st.rxMode == RX_PREACK) else $error("pre-acknowledge missing");

  abort_hold_a: assert property (
    clkEn && frameDone && st.rxMode == RX_ABORT |=> !st.aDrive && st.rxMode == RX_IGNORE)
    else $error("abort request not held low");

  open_gate_a: assert property (
    $rose(st.eDrive) |-> st.aIdleRun == RUN_TWO && st.txState == TX_SEND)
    else $error("reply opened without idle acknowledge");

  msb_first_a: assert property (
    clkEn && driveNow && bitIdx == MON_FIRST_BIT && st.eDrive
    |=> transmitDataOe == ~st.txByte[7]) else $error("reply not sent msb first");

  power_cmd_a: assert property (
    clkEn && frameDone && eActNow && st.rxMode == RX_NEXT && sameByte && st.phase == PH_INSTR
    |=> powerDown == $past(st.shiftIn[INSTR_POWER])) else $error("power bit not applied");

  idle_reset_a: assert property (
    clkEn && clocksIdle |=> st.rxMode == RX_IDLE && !transmitDataOe && powerDown)
    else $error("handshake survives stopped clocks");

  reply_sent_c: cover property (st.txState == TX_SEND ##1 st.txState == TX_CLOSE);
  format_wr_c:  cover property (st.memWe && st.pushEntry.code == REG_FORMAT);
  abort_c:      cover property (st.rxMode == RX_ABORT);
  fifo_full_c:  cover property (!fifoReady);
endmodule : gci_monitor_register_access

// >>> verif/gci_ctrl_model.sv
// controller model: makes link clock and frame sync, sends bytes, samples device
// assumes device output is open drain, wire pulled up
module gci_ctrl_model (
  output logic      bitClk,    // link bit clock
  output logic      frameSync, // frame start
  output logic      rxd,       // data toward device
  input  wire logic devOe      // device pulls low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] tx;
  logic [63:0] rx;
  logic [7:0]  rb; // byte seen from device
  logic        ra; // device acknowledge active
  logic        re; // device byte-present active
  initial begin
    bitClk = 1'b0;
    frameSync = 1'b0;
    rxd = 1'b1;
  end
  //////////////////////////////////////////////////////////////
  // one frame; clock only runs inside frames, E and A low active
  task fr(input bit e, input bit a, input logic [7:0] b);
    tx = {48'hFFFF_FFFF_FFFF, b, 6'h3F, ~a, ~e};
    for (int h = 0; h < 128; h++) begin
      frameSync = (h < 2);
      // uneven halves keep every link edge on a falling ref_clk edge
      #60 bitClk = 1'b1;
      if (h[0]) rx[63-h/2] = ~devOe;
      else rxd = tx[63-h/2];
      #65 bitClk = 1'b0;
    end
    rb = rx[15:8];
    ra = ~rx[1];
    re = ~rx[0];
  endtask : fr
endmodule : gci_ctrl_model

// >>> verif/tb_gci_monitor_register_access.sv
// bench: writes and reads registers over the monitor channel, checks queue output
// assumes controller model beside the block, address pins strapped to 4'h5
module tb_gci_monitor_register_access;
  import gci_mon_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clkEn = 1'b1;
  logic        wrReady = 1'b0;
  logic [3:0]  pins = 4'h5;
  logic        bitClk, frameSync, rxd, txPin, txOe, powerDown, wrValid;
  format_cfg_t fmt;
  reg_write_t  wrEntry;
  int          n_errors = 0;
  int          n_compared = 0;
  int          seed = 32'he363;
  logic [11:0] q[$];
  logic [7:0]  d;
  always #2.5 ref_clk = ~ref_clk;
  gci_monitor_register_access u_dut (.ref_clk, .rst_n, .clkEn, .bitClk, .frameSync,
    .receiveDataPin(rxd), .deviceAddressPins(pins), .transmitDataPin(txPin),
    .transmitDataOe(txOe), .formatConfig(fmt), .powerDown, .wrValid, .wrReady, .wrEntry);
  gci_ctrl_model u_ctrl (.bitClk, .frameSync, .rxd, .devOe(txOe));
  //////////////////////////////////////////////////////////////
  task chk(input logic [11:0] s, input logic [11:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("Error %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task wrap_up;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // later bytes open with one E-idle frame; each byte held two frames
  task putB(input bit first, input logic [7:0] b);
    if (!first) begin
      u_ctrl.fr(1'b0, 1'b0, b);
      chk(12'(u_ctrl.ra), 12'h1);
    end
    u_ctrl.fr(1'b1, 1'b0, b);
    u_ctrl.fr(1'b1, 1'b0, b);
    if (!first) chk(12'(u_ctrl.ra), 12'h0);
  endtask : putB
  //////////////////////////////////////////////////////////////
  // random consumer stalls and clock-enable gaps, changed on the falling edge
  always @(negedge ref_clk) begin
    wrReady <= 1'($random(seed));
    clkEn   <= 3'($random(seed)) != 3'h0;
  end
  // a pop needs the enable too: the queue is frozen while it is low
  always @(posedge ref_clk)
    if (wrValid === 1'b1 && wrReady && clkEn) chk(wrEntry, q.size() ? q.pop_front() : 12'hXXX);
  // thirty frames of 16 us plus the clock-stop wait end near 485 us
  initial begin
    #500_000;
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (3) @(negedge ref_clk);
    chk(12'(fmt), 12'h000);
    chk(12'({powerDown, txOe, wrValid, txPin}), 12'h8);
    rst_n = 1'b1;
    d = 8'($random(seed));
    putB(1'b1, 8'hA0);
    u_ctrl.fr(1'b0, 1'b0, 8'hFF);
    chk(12'(u_ctrl.ra), 12'h0);
    u_ctrl.fr(1'b0, 1'b0, 8'hFF);
    putB(1'b1, 8'h50);
    putB(1'b0, 8'h02);
    q.push_back({REG_FORMAT, 8'hA5});
    putB(1'b0, 8'hA5);
    putB(1'b0, 8'h12);
    q.push_back({4'h2, d});
    putB(1'b0, d);
    // a byte that differs in its second frame is aborted: A stays idle, nothing written
    u_ctrl.fr(1'b0, 1'b0, d);
    chk(12'(u_ctrl.ra), 12'h1);
    u_ctrl.fr(1'b1, 1'b0, ~d);
    u_ctrl.fr(1'b0, 1'b0, 8'hFF);
    chk(12'(u_ctrl.ra), 12'h0);
    u_ctrl.fr(1'b0, 1'b0, 8'hFF);
    chk(12'(u_ctrl.ra), 12'h0);
    chk(12'(fmt), 12'h0A5);
    chk(12'(powerDown), 12'h0);
    putB(1'b1, 8'h50);
    putB(1'b0, 8'h06);
    // the reply starts in the frame after the two that end the read message
    u_ctrl.fr(1'b0, 1'b0, 8'hFF);
    chk(12'(u_ctrl.ra), 12'h1);
    for (int i = 0; i < 4 && u_ctrl.re !== 1'b1; i++) u_ctrl.fr(1'b0, 1'b0, 8'hFF);
    chk({3'h0, u_ctrl.re, u_ctrl.rb}, 12'h1A5);
    u_ctrl.fr(1'b0, 1'b1, 8'hFF);
    u_ctrl.fr(1'b0, 1'b1, 8'hFF);
    chk(12'(u_ctrl.re), 12'h0);
    chk(12'(u_ctrl.ra), 12'h0);
    chk(12'(q.size()), 12'h000);
    // stopped link clocks must release the line and power down
    repeat (1000) @(negedge ref_clk);
    chk(12'({powerDown, txOe}), 12'h2);
    wrap_up();
  end
endmodule : tb_gci_monitor_register_access
